// ==== bench/nsu_core_model.sv ====
// Flags source standing in for the core status register
`timescale 1ns/100ps
module nsu_core_model (
    // Clock
    input wire logic clock_i,
    // Flags
    output logic [4:0] status_o
);
    initial status_o = 5'h00;
    always @(posedge clock_i)
        status_o <= status_o + 5'h07;
endmodule

// ==== bench/nsu_props.sv ====
// Checker for the nibble exchange unit
`timescale 1ns/100ps
module nsu_props (
    // Inputs
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic start_i,
    input wire nsu_pkg::nsu_op_t op_i,
    input wire logic [3:0] bank_pointer_i,
    input wire logic ext_set_en_i,
    input wire logic [11:0] index_base_i,
    input wire logic [4:0] status_i,
    // Outputs
    input wire logic [7:0] acc_o,
    input wire logic [4:0] status_o,
    input wire logic [11:0] addr_o,
    input wire logic done_o,
    input wire logic busy_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    sequence take;
        ce_i && start_i && !busy_o;
    endsequence
    sequence finish;
        busy_o ##1 (done_o && !busy_o);
    endsequence
    done_timing_a: assert property (take |=> finish)
        else $error("done timing");
    flags_kept_a: assert property ($past(nrst_i) && $past(ce_i) |->
        status_o == $past(status_i)) else $error("flags changed");
    frozen_state_a: assert property (!ce_i |=> $stable(status_o) && $stable(acc_o)
        && $stable(done_o) && $stable(busy_o)) else $error("state moved while frozen");
    acc_at_done_a: assert property ($changed(acc_o) |-> done_o)
        else $error("acc changed outside write");
    acc_kept_a: assert property (take ##0 op_i.dest_sel |=> ##1 $stable(acc_o))
        else $error("acc written");
    bank_addr_a: assert property (take ##0 op_i.bank_sel |=>
        addr_o == {$past(bank_pointer_i), $past(op_i.file_addr)}) else $error("bank addr");
    access_addr_a: assert property (take ##0 !op_i.bank_sel && !ext_set_en_i |=>
        addr_o == {{4{$past(op_i.file_addr[7])}}, $past(op_i.file_addr)})
        else $error("access addr");
    index_addr_a: assert property (take ##0 !op_i.bank_sel && ext_set_en_i
        && op_i.file_addr <= 8'h5F |=> addr_o == $past(index_base_i)
        + {4'h0, $past(op_i.file_addr)}) else $error("index addr");
endmodule

// ==== bench/nsu_tb.sv ====
// Self-checking bench for the nibble exchange unit
`timescale 1ns/100ps
module testbench;
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    logic start_i = 1'b0;
    logic ce_i = 1'b1;
    logic ext_set_en_i = 1'b0;
    logic [3:0] bank_pointer_i = 4'h0;
    logic [11:0] index_base_i = 12'h000;
    nsu_pkg::nsu_op_t op_i = '0;
    logic [4:0] status_i, status_o;
    logic [7:0] acc_o;
    logic [11:0] addr_o;
    logic done_o, busy_o;
    int n_mismatch = 0;
    int n_checks = 0;
    nsu_core_model nsu_core_model_inst (.clock_i(clock_i), .status_o(status_i));
    nsu_unit nsu_unit_inst (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i),
        .start_i(start_i), .op_i(op_i), .bank_pointer_i(bank_pointer_i),
        .ext_set_en_i(ext_set_en_i), .index_base_i(index_base_i), .status_i(status_i),
        .acc_o(acc_o), .status_o(status_o), .addr_o(addr_o), .done_o(done_o),
        .busy_o(busy_o));
    task automatic cmp(input logic [11:0] got, exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("mismatches=%0d checks=%0d", n_mismatch, n_checks);
        if (n_mismatch == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic preload(input logic [11:0] a, input logic [7:0] v);
        nsu_unit_inst.u_mem.mem[a] = v;
    endtask
    task automatic run_op(input logic [7:0] fa, input logic b, d, hold, input logic [11:0] ea,
        input logic [7:0] acc_exp);
        @(posedge clock_i);
        start_i <= 1'b1;
        op_i <= '{fa, d, b};
        @(posedge clock_i);
        start_i <= hold;
        op_i.file_addr <= ~fa;
        @(posedge clock_i);
        start_i <= 1'b0;
        #1;
        cmp(done_o, 1'b1);
        cmp(addr_o, ea);
        cmp(status_o, 5'(status_i - 5'h07));
        @(posedge clock_i);
        #1;
        cmp(busy_o, 1'b0);
        cmp(acc_o, acc_exp);
    endtask
    task automatic t_access();
        preload(12'h07F, 8'h53);
        preload(12'hF80, 8'hA6);
        run_op(8'h7F, 1'b0, 1'b1, 1'b0, 12'h07F, 8'h00);
        run_op(8'h7F, 1'b0, 1'b0, 1'b0, 12'h07F, 8'h53);
        run_op(8'h80, 1'b0, 1'b0, 1'b1, 12'hF80, 8'h6A);
    endtask
    task automatic t_freeze();
        logic [4:0] s;
        logic [7:0] a;
        @(posedge clock_i);
        ce_i <= 1'b0;
        start_i <= 1'b1;
        op_i <= '{8'h7F, 1'b0, 1'b0};
        @(posedge clock_i);
        #1;
        s = status_o;
        a = acc_o;
        repeat (3) @(posedge clock_i);
        #1;
        cmp(status_o, s);
        cmp(busy_o, 1'b0);
        cmp(acc_o, a);
        @(posedge clock_i);
        ce_i <= 1'b1;
        start_i <= 1'b0;
    endtask
    task automatic t_modes();
        @(posedge clock_i);
        bank_pointer_i <= 4'hA;
        ext_set_en_i <= 1'b1;
        index_base_i <= 12'h200;
        preload(12'h25F, 8'h1E);
        preload(12'h060, 8'hC4);
        preload(12'hA3C, 8'h29);
        run_op(8'h5F, 1'b0, 1'b0, 1'b0, 12'h25F, 8'hE1);
        run_op(8'h60, 1'b0, 1'b0, 1'b1, 12'h060, 8'h4C);
        run_op(8'h3C, 1'b1, 1'b1, 1'b0, 12'hA3C, 8'h4C);
        run_op(8'h3C, 1'b1, 1'b0, 1'b0, 12'hA3C, 8'h29);
    endtask
    initial
        forever #2 clock_i = ~clock_i;
    initial
    begin
        #4000;
        n_mismatch++;
        conclude();
    end
    initial
    begin
        repeat (6) @(posedge clock_i);
        nrst_i <= 1'b1;
        t_access();
        t_freeze();
        t_modes();
        conclude();
    end
endmodule
bind nsu_unit nsu_props nsu_props_inst (.*);

// ==== rtl/nsu_mem.sv ====
// Data memory with registered read port
`timescale 1ns/100ps
module nsu_mem #(
    parameter int DW = 8,
    parameter int AW = 12
) (
    // Clock
    input wire logic clock_i,
    input wire logic ce_i,
    // Read port
    input wire logic [AW-1:0] raddr_i,
    output logic [DW-1:0] rdata_o,
    // Write port
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [DW-1:0] wdata_i
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clock_i)
    begin
        if (ce_i && we_i)
        begin
            mem[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (ce_i)
        begin
            rdata_o <= mem[raddr_i];
        end
    end
endmodule

// ==== rtl/nsu_pkg.sv ====
// Package with constants and carrier types for the nibble exchange unit
package nsu_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 12;
    localparam int BANK_W = 4;
    localparam int NIB_W = 4;
    localparam int MEM_DEPTH = 4096;
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [7:0] IDX_LIMIT = 8'h5F;
    localparam logic [BANK_W-1:0] ACCESS_LO_BANK = 4'h0;
    localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 4'hF;
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic [4:0] STATUS_RESET = 5'h00;

    typedef struct packed {
        logic [7:0] file_addr;
        logic dest_sel;
        logic bank_sel;
    } nsu_op_t;

    typedef enum logic [1:0] {
        NSU_IDLE = 2'b00,
        NSU_READ = 2'b01,
        NSU_WRITE = 2'b10
    } nsu_state_t;
endpackage

// ==== rtl/nsu_unit.sv ====
// Nibble exchange instruction datapath
// Notes on behaviour
// - Result is source byte with upper and lower nibbles exchanged.
// - Destination bit 0 writes accumulator; 1 writes back to source location.
// - Bank bit 0 addresses the fixed access bank by file address.
// - Bank bit 1 takes upper address bits from the bank pointer.
// - Extended set with bank bit 0 uses indexed offset for addresses to 95.
`timescale 1ns/100ps
module nsu_unit #(
    parameter int DW = nsu_pkg::DATA_W,
    parameter int AW = nsu_pkg::ADDR_W
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    // Instruction
    input wire logic start_i,
    input wire nsu_pkg::nsu_op_t op_i,
    input wire logic [nsu_pkg::BANK_W-1:0] bank_pointer_i,
    input wire logic ext_set_en_i,
    input wire logic [AW-1:0] index_base_i,
    input wire logic [4:0] status_i,
    // Results
    output logic [DW-1:0] acc_o,
    output logic [4:0] status_o,
    output logic [AW-1:0] addr_o,
    output logic done_o,
    output logic busy_o
);
    initial
    begin
        if (DW != nsu_pkg::DATA_W)
        begin
            $error("nsu_unit supports only 8-bit data");
        end
        if (AW != nsu_pkg::ADDR_W)
        begin
            $error("nsu_unit supports only 12-bit addresses");
        end
        if (2 * nsu_pkg::NIB_W != DW)
        begin
            $error("nsu_unit needs two nibbles per data word");
        end
        if (nsu_pkg::BANK_W + 8 != AW)
        begin
            $error("nsu_unit needs bank bits plus file address to fill the address");
        end
        if ((1 << AW) != nsu_pkg::MEM_DEPTH)
        begin
            $error("nsu_unit memory depth must match the address width");
        end
        if (nsu_pkg::IDX_LIMIT >= nsu_pkg::ACCESS_SPLIT)
        begin
            $error("nsu_unit indexed window must lie in the lower access half");
        end
    end

    nsu_pkg::nsu_state_t state_r;
    nsu_pkg::nsu_op_t op_r;
    logic [AW-1:0] addr_r;
    logic [AW-1:0] addr_nxt;
    logic [DW-1:0] rdata;
    logic mem_we;
    logic accept;
    logic write_cycle;
    logic [AW-1:0] idx_sum;

    function automatic logic [DW-1:0] nib_swap(input logic [DW-1:0] v);
        nib_swap = {v[nsu_pkg::NIB_W-1:0], v[DW-1:nsu_pkg::NIB_W]};
    endfunction

    // Handshake qualifiers
    assign accept = ce_i && (state_r == nsu_pkg::NSU_IDLE) && start_i;
    assign write_cycle = (state_r == nsu_pkg::NSU_WRITE);
    assign idx_sum = index_base_i + {{nsu_pkg::BANK_W{1'b0}}, op_i.file_addr};

    always_comb
    begin
        if (op_i.bank_sel)
        begin
            addr_nxt = {bank_pointer_i, op_i.file_addr};
        end
        else if (ext_set_en_i && op_i.file_addr <= nsu_pkg::IDX_LIMIT)
        begin
            addr_nxt = idx_sum;
        end
        else if (op_i.file_addr < nsu_pkg::ACCESS_SPLIT)
        begin
            addr_nxt = {nsu_pkg::ACCESS_LO_BANK, op_i.file_addr};
        end
        else
        begin
            addr_nxt = {nsu_pkg::ACCESS_HI_BANK, op_i.file_addr};
        end
    end

    assign mem_we = (state_r == nsu_pkg::NSU_WRITE) && op_r.dest_sel;

    nsu_mem #(.DW(DW), .AW(AW)) u_mem (
        .clock_i(clock_i),
        .ce_i(ce_i),
        .raddr_i(addr_nxt),
        .rdata_o(rdata),
        .we_i(mem_we),
        .waddr_i(addr_r),
        .wdata_i(nib_swap(rdata))
    );

    // Sequencer: capture/read, then write
    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            state_r <= nsu_pkg::NSU_IDLE;
        end
        else if (ce_i)
        begin
            unique case (state_r)
                nsu_pkg::NSU_IDLE:
                begin
                    if (start_i)
                    begin
                        state_r <= nsu_pkg::NSU_WRITE;
                    end
                end
                nsu_pkg::NSU_WRITE:
                begin
                    state_r <= nsu_pkg::NSU_IDLE;
                end
                default:
                begin
                    state_r <= nsu_pkg::NSU_IDLE;
                end
            endcase
        end
    end

    // Operand capture at accept
    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            op_r <= '0;
            addr_r <= '0;
        end
        else if (accept)
        begin
            op_r <= op_i;
            addr_r <= addr_nxt;
        end
    end

    // Completion pulse
    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            done_o <= 1'b0;
        end
        else if (ce_i)
        begin
            done_o <= write_cycle;
        end
    end

    // Busy flag
    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            busy_o <= 1'b0;
        end
        else if (ce_i)
        begin
            busy_o <= accept;
        end
    end

    // Resolved address
    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            addr_o <= '0;
        end
        else if (ce_i)
        begin
            if (accept)
            begin
                addr_o <= addr_nxt;
            end
        end
    end

    // Accumulator
    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            acc_o <= nsu_pkg::ACC_RESET;
        end
        else if (ce_i)
        begin
            if (write_cycle && !op_r.dest_sel)
            begin
                acc_o <= nib_swap(rdata);
            end
        end
    end

    // Status passes through untouched
    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            status_o <= nsu_pkg::STATUS_RESET;
        end
        else if (ce_i)
        begin
            status_o <= status_i;
        end
    end
endmodule
